// [pkg/dis_regs.vh]
// Constants for the dual serial slave ports block
`ifndef DIS_REGS_VH
`define DIS_REGS_VH

// Wishbone register byte offsets
`define DIS_REG_CTRL        8'h00
`define DIS_REG_STATUS      8'h04
`define DIS_REG_ADDR_REMOTE 8'h08
`define DIS_REG_ADDR_IDENT  8'h0C
`define DIS_REG_ADDR_GAMUT  8'h10

// Control register fields
`define DIS_CTRL_PWR_N      0
`define DIS_CTRL_CORE_SEL   1
`define DIS_CTRL_SOFT_RST   2
`define DIS_CTRL_RESET      2'h1

// Status register fields
`define DIS_STAT_SYNC       0
`define DIS_STAT_CLOCK      1
`define DIS_STAT_STRAP      2
`define DIS_STAT_CH_BUSY    3
`define DIS_STAT_LOC_BUSY   4

// Slave addresses, seven bit
`define DIS_CH_ADDR         7'h3A
`define DIS_CTRL_A_LOW      7'h30
`define DIS_CTRL_A_HIGH     7'h31
`define DIS_CTRL_B_LOW      7'h34
`define DIS_CTRL_B_HIGH     7'h35
`define DIS_REMOTE_RESET    7'h40
`define DIS_IDENT_RESET     7'h50
`define DIS_GAMUT_RESET     7'h70

// Pointer value after reset and after stop
`define DIS_PTR_DEFAULT     8'h08

// Local port top serial clock rate
`define DIS_LOC_SCL_MAX_KHZ 400

`endif

// [logic/dis_sync2.v]
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/10ps
`default_nettype none
module dis_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         sys_clk,
    input  wire         sys_rst,
    // Asynchronous input and synchronised output
    input  wire [W-1:0] async_i,
    output wire [W-1:0] sync_o
);
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_q <= {W{1'b1}};
            sync_q <= {W{1'b1}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;
endmodule // dis_sync2
`default_nettype wire

// [logic/dis_regmem.v]
// Byte register store with registered read data
`timescale 1ns/10ps
`default_nettype none
module dis_regmem #(
    parameter AW = 11
) (
    // Clock
    input  wire          sys_clk,
    // Write port
    input  wire          wr_en,
    input  wire [AW-1:0] addr,
    input  wire [7:0]    wr_data,
    // Read port
    output reg  [7:0]    rd_data
);
    reg [7:0] mem [0:(1<<AW)-1];

    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
        rd_data <= mem[addr];
    end
endmodule // dis_regmem
`default_nettype wire

// [logic/dis_top.v]
// Dual serial slave ports: display data channel and local configuration
// Overview of operation
// - Channel port answers at one fixed seven-bit slave address.
// - Reads and writes carry any number of data bytes.
// - Each byte acknowledged except last read byte, which master leaves unacknowledged.
// - Pointer advances after every data byte, low byte first.
// - Channel port accepts a read with no register address phase.
// - Pointer returns to link-verify offset after resets and after stop.
// - Local port is a separate bus with standard reads and writes only.
// - Local port refuses reads not preceded by a register address phase.
// - Local slave works at serial clock rates up to 400 kHz.
// - Local port decodes five slave addresses, each its own register group.
// - Strap bit loads from its synchroniser, which reset holds at one, so both control groups always use the high addresses.
// - Remote, identification and gamut group addresses are software writable.
// - Register access needs no running video clock.
// - Read-write registers read back the last value written.
// - Stream status registers may be undefined without video clock and syncs.
// - Sync-detect and clock-detect status bits show active video.
// - Active-low power-down bit puts the device in standby.
// - Core select enables one input core; termination of both stays on.
`timescale 1ns/10ps
`default_nettype none
`include "dis_regs.vh"
module dis_top (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        sys_rst,
    // Wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // Display data channel pins
    input  wire        channel_serial_clock,
    input  wire        channel_serial_data_i,
    output wire        channel_serial_data_o,
    output wire        channel_serial_data_oe,
    // Local configuration pins
    input  wire        local_serial_clock,
    input  wire        local_serial_data_i,
    output wire        local_serial_data_o,
    output wire        local_serial_data_oe,
    // Straps and video status
    input  wire        addr_strap_pin,
    input  wire        sync_detect_flag,
    input  wire        clock_detect_flag,
    // Power and core control
    output reg         standby_o,
    output reg  [1:0]  core_enable_o,
    output reg  [1:0]  term_enable_o
);
    localparam ST_IDLE  = 8'h01;
    localparam ST_ADDR  = 8'h02;
    localparam ST_AACK  = 8'h04;
    localparam ST_REGA  = 8'h08;
    localparam ST_WRITE = 8'h10;
    localparam ST_WACK  = 8'h20;
    localparam ST_READ  = 8'h40;
    localparam ST_RACK  = 8'h80;

    // Synchronised pins
    wire [5:0] sync_w;
    wire [1:0] scl_s;
    wire [1:0] sda_s;
    wire       strap_s;
    wire       vsync_s;
    wire       vclk_s;

    // Software control state
    reg        power_n_q;
    reg        core_sel_q;
    reg        soft_rst_q;
    reg [6:0]  addr_remote_q;
    reg [6:0]  addr_ident_q;
    reg [6:0]  addr_gamut_q;
    reg        strap_q;
    wire [1:0] busy_w;
    wire [1:0] sda_oe_w;

    // Pins cross into the bus clock before use; at 20 MHz a 400 kHz
    // clock high phase still spans many samples
    dis_sync2 #(
        .W (6)
    ) u_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .async_i ({clock_detect_flag, sync_detect_flag, addr_strap_pin,
                   local_serial_data_i, channel_serial_data_i,
                   local_serial_clock}),
        .sync_o  (sync_w)
    );

    dis_sync2 #(
        .W (1)
    ) u_sync_ch_clk (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .async_i (channel_serial_clock),
        .sync_o  (scl_s[0])
    );

    assign scl_s[1] = sync_w[0];
    assign sda_s    = sync_w[2:1];
    assign strap_s  = sync_w[3];
    assign vsync_s  = sync_w[4];
    assign vclk_s   = sync_w[5];

    // Strap loaded while reset is held, when its synchroniser reads one; frozen afterwards
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            strap_q <= strap_s;
        end
    end

    // Open drain: only ever pull low
    assign channel_serial_data_o  = 1'b0;
    assign local_serial_data_o    = 1'b0;
    assign channel_serial_data_oe = sda_oe_w[0];
    assign local_serial_data_oe   = sda_oe_w[1];

    // Port 0 is the data channel, port 1 the separate local bus
    genvar p;
    generate
        for (p = 0; p < 2; p = p + 1) begin : g_port
            reg  [7:0]  st_q;
            reg  [7:0]  sh_q;
            reg  [3:0]  cnt_q;
            reg  [7:0]  ptr_q;
            reg  [2:0]  grp_q;
            reg         rw_q;
            reg         ptr_set_q;
            reg         oe_q;
            reg         mack_q;
            reg         scl_p_q;
            reg         sda_p_q;
            reg         wr_q;
            reg         hit;
            reg  [2:0]  hit_grp;
            wire [7:0]  rd_data;
            wire        start_w;
            wire        stop_w;
            wire        rise_w;
            wire        fall_w;

            assign start_w = scl_s[p] & scl_p_q & sda_p_q & ~sda_s[p];
            assign stop_w  = scl_s[p] & scl_p_q & ~sda_p_q & sda_s[p];
            assign rise_w  = scl_s[p] & ~scl_p_q;
            assign fall_w  = ~scl_s[p] & scl_p_q;

            // Slave address decode on the byte just shifted in
            always @* begin
                hit     = 1'b0;
                hit_grp = 3'h0;
                if (p == 0) begin
                    hit = (sh_q[7:1] == `DIS_CH_ADDR);
                end else if (sh_q[7:1] == (strap_q ? `DIS_CTRL_A_HIGH
                                                   : `DIS_CTRL_A_LOW)) begin
                    hit = 1'b1;
                end else if (sh_q[7:1] == (strap_q ? `DIS_CTRL_B_HIGH
                                                   : `DIS_CTRL_B_LOW)) begin
                    hit     = 1'b1;
                    hit_grp = 3'h1;
                end else if (sh_q[7:1] == addr_remote_q) begin
                    hit     = 1'b1;
                    hit_grp = 3'h2;
                end else if (sh_q[7:1] == addr_ident_q) begin
                    hit     = 1'b1;
                    hit_grp = 3'h3;
                end else if (sh_q[7:1] == addr_gamut_q) begin
                    hit     = 1'b1;
                    hit_grp = 3'h4;
                end
            end

            always @(posedge sys_clk) begin
                if (sys_rst) begin
                    st_q      <= ST_IDLE;
                    sh_q      <= 8'h00;
                    cnt_q     <= 4'h0;
                    ptr_q     <= `DIS_PTR_DEFAULT;
                    grp_q     <= 3'h0;
                    rw_q      <= 1'b0;
                    ptr_set_q <= 1'b0;
                    oe_q      <= 1'b0;
                    mack_q    <= 1'b0;
                    scl_p_q   <= 1'b1;
                    sda_p_q   <= 1'b1;
                    wr_q      <= 1'b0;
                end else begin
                    scl_p_q <= scl_s[p];
                    sda_p_q <= sda_s[p];
                    wr_q    <= 1'b0;
                    if (stop_w) begin
                        st_q      <= ST_IDLE;
                        oe_q      <= 1'b0;
                        ptr_set_q <= 1'b0;
                        ptr_q     <= `DIS_PTR_DEFAULT;
                    end else if (start_w) begin
                        // Repeated start keeps the pointer already loaded
                        st_q  <= ST_ADDR;
                        cnt_q <= 4'h0;
                        oe_q  <= 1'b0;
                    end else begin
                        if (soft_rst_q) begin
                            ptr_q <= `DIS_PTR_DEFAULT;
                        end
                        case (st_q)
                            ST_IDLE: begin
                                oe_q <= 1'b0;
                            end
                            ST_ADDR, ST_REGA, ST_WRITE: begin
                                if (rise_w) begin
                                    sh_q  <= {sh_q[6:0], sda_s[p]};
                                    cnt_q <= cnt_q + 4'h1;
                                end else if (fall_w && cnt_q == 4'h8) begin
                                    cnt_q <= 4'h0;
                                    if (st_q == ST_ADDR) begin
                                        // No short read on the local port
                                        if (hit && !(p == 1 && sh_q[0] &&
                                                     !ptr_set_q)) begin
                                            oe_q  <= 1'b1;
                                            rw_q  <= sh_q[0];
                                            grp_q <= hit_grp;
                                            st_q  <= ST_AACK;
                                        end else begin
                                            st_q <= ST_IDLE;
                                        end
                                    end else if (st_q == ST_REGA) begin
                                        ptr_q     <= sh_q;
                                        ptr_set_q <= 1'b1;
                                        oe_q      <= 1'b1;
                                        st_q      <= ST_WACK;
                                    end else begin
                                        wr_q  <= 1'b1;
                                        oe_q  <= 1'b1;
                                        st_q  <= ST_WACK;
                                    end
                                end
                            end
                            ST_AACK: begin
                                if (fall_w) begin
                                    cnt_q <= 4'h0;
                                    if (rw_q) begin
                                        sh_q <= {rd_data[6:0], 1'b0};
                                        oe_q <= ~rd_data[7];
                                        st_q <= ST_READ;
                                    end else begin
                                        oe_q <= 1'b0;
                                        st_q <= ST_REGA;
                                    end
                                end
                            end
                            ST_WACK: begin
                                if (wr_q) begin
                                    ptr_q <= ptr_q + 8'h01;
                                end
                                if (fall_w) begin
                                    oe_q  <= 1'b0;
                                    cnt_q <= 4'h0;
                                    st_q  <= ST_WRITE;
                                end
                            end
                            ST_READ: begin
                                if (rise_w) begin
                                    cnt_q <= cnt_q + 4'h1;
                                end else if (fall_w) begin
                                    if (cnt_q == 4'h8) begin
                                        oe_q  <= 1'b0;
                                        ptr_q <= ptr_q + 8'h01;
                                        st_q  <= ST_RACK;
                                    end else begin
                                        oe_q <= ~sh_q[7];
                                        sh_q <= {sh_q[6:0], 1'b0};
                                    end
                                end
                            end
                            ST_RACK: begin
                                if (rise_w) begin
                                    mack_q <= ~sda_s[p];
                                end else if (fall_w) begin
                                    cnt_q <= 4'h0;
                                    if (mack_q) begin
                                        sh_q <= {rd_data[6:0], 1'b0};
                                        oe_q <= ~rd_data[7];
                                        st_q <= ST_READ;
                                    end else begin
                                        st_q <= ST_IDLE;
                                    end
                                end
                            end
                            default: begin
                                st_q <= ST_IDLE;
                                oe_q <= 1'b0;
                            end
                        endcase
                    end
                end
            end

            // Write enable lags one cycle; pointer advances on the same edge as the write
            dis_regmem #(
                .AW (11)
            ) u_mem (
                .sys_clk (sys_clk),
                .wr_en   (wr_q),
                .addr    ({grp_q, ptr_q}),
                .wr_data (sh_q),
                .rd_data (rd_data)
            );

            assign sda_oe_w[p] = oe_q;
            assign busy_w[p]   = ~st_q[0];
        end
    endgenerate

    // Wishbone slave: ack one cycle after request, drop next cycle
    wire       wb_req = wb_cyc_i & wb_stb_i;
    wire       wb_wr  = wb_req & wb_we_i & wb_ack_o & wb_sel_i[0];
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            `DIS_REG_CTRL: begin
                rd_mux[`DIS_CTRL_PWR_N]    = power_n_q;
                rd_mux[`DIS_CTRL_CORE_SEL] = core_sel_q;
            end
            `DIS_REG_STATUS: begin
                // Stream status is meaningless while no video arrives
                rd_mux[`DIS_STAT_SYNC]     = vsync_s;
                rd_mux[`DIS_STAT_CLOCK]    = vclk_s;
                rd_mux[`DIS_STAT_STRAP]    = strap_q;
                rd_mux[`DIS_STAT_CH_BUSY]  = busy_w[0];
                rd_mux[`DIS_STAT_LOC_BUSY] = busy_w[1];
            end
            `DIS_REG_ADDR_REMOTE: rd_mux[6:0] = addr_remote_q;
            `DIS_REG_ADDR_IDENT:  rd_mux[6:0] = addr_ident_q;
            `DIS_REG_ADDR_GAMUT:  rd_mux[6:0] = addr_gamut_q;
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            wb_ack_o      <= 1'b0;
            wb_dat_o      <= 32'h0000_0000;
            power_n_q     <= 1'b1;
            core_sel_q    <= 1'b0;
            soft_rst_q    <= 1'b0;
            addr_remote_q <= `DIS_REMOTE_RESET;
            addr_ident_q  <= `DIS_IDENT_RESET;
            addr_gamut_q  <= `DIS_GAMUT_RESET;
        end else begin
            wb_ack_o   <= wb_req & ~wb_ack_o;
            wb_dat_o   <= rd_mux;
            soft_rst_q <= 1'b0;
            if (wb_wr) begin
                case (wb_adr_i)
                    `DIS_REG_CTRL: begin
                        power_n_q  <= wb_dat_i[`DIS_CTRL_PWR_N];
                        core_sel_q <= wb_dat_i[`DIS_CTRL_CORE_SEL];
                        soft_rst_q <= wb_dat_i[`DIS_CTRL_SOFT_RST];
                    end
                    `DIS_REG_ADDR_REMOTE: addr_remote_q <= wb_dat_i[6:0];
                    `DIS_REG_ADDR_IDENT:  addr_ident_q  <= wb_dat_i[6:0];
                    `DIS_REG_ADDR_GAMUT:  addr_gamut_q  <= wb_dat_i[6:0];
                    default: begin
                        soft_rst_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Power and core enables
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            standby_o     <= 1'b0;
            core_enable_o <= 2'b01;
            term_enable_o <= 2'b11;
        end else begin
            standby_o     <= ~power_n_q;
            core_enable_o <= power_n_q ? (core_sel_q ? 2'b10 : 2'b01)
                                       : 2'b00;
            term_enable_o <= 2'b11;
        end
    end
endmodule // dis_top
`default_nettype wire

// [tb/dis_checker.sv]
// Port-level assertions for the dual serial slave block
`timescale 1ns/10ps
`default_nettype none
module dis_checker (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    // Bus handshake
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    // Serial pins
    input wire logic       channel_serial_clock,
    input wire logic       channel_serial_data_oe,
    input wire logic       local_serial_clock,
    input wire logic       local_serial_data_oe,
    // Power and cores
    input wire logic       standby_o,
    input wire logic [1:0] core_enable_o,
    input wire logic [1:0] term_enable_o
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("bus ack without request");
    a_ch_sda_scl_low: assert property ($changed(channel_serial_data_oe) |-> !channel_serial_clock)
        else $error("channel data moved while clock high");
    a_loc_sda_scl_low: assert property ($changed(local_serial_data_oe) |-> !local_serial_clock)
        else $error("local data moved while clock high");
    a_term_both_on: assert property (term_enable_o == 2'h3)
        else $error("termination switched off");
    a_standby_cores_off: assert property (standby_o |-> core_enable_o == 2'h0)
        else $error("core enabled in standby");
    a_active_one_core: assert property (!standby_o |-> $onehot(core_enable_o))
        else $error("not exactly one core enabled");
    a_reset_power_on: assert property ($fell(sys_rst) |-> !standby_o && core_enable_o == 2'h1)
        else $error("wrong power state after reset");
endmodule // dis_checker
bind dis_top dis_checker i_dis_checker (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .channel_serial_clock(channel_serial_clock),
    .channel_serial_data_oe(channel_serial_data_oe), .local_serial_clock(local_serial_clock),
    .local_serial_data_oe(local_serial_data_oe), .standby_o(standby_o),
    .core_enable_o(core_enable_o), .term_enable_o(term_enable_o)
);
`default_nettype wire

// [tb/dis_i2c_master.sv]
// Serial bus master model for one open-drain port
`timescale 1ns/10ps
`default_nettype none
module dis_i2c_master #(
    parameter int H = 10
) (
    // Clock
    input  wire logic sys_clk,
    // Slave pull-down and resolved pins
    input  wire logic slave_oe,
    output var  logic scl,
    output wire logic sda
);
    logic drv_low;
    initial begin
        scl = 1'b1;
        drv_low = 1'b0;
    end
    // Pull-up wins unless someone pulls low
    assign sda = !(drv_low || slave_oe);
    // Data set while clock low, sampled at end of high phase
    task bit_io(input logic b, output logic r);
        @(posedge sys_clk) drv_low <= !b;
        repeat (H) @(posedge sys_clk);
        scl <= 1'b1;
        repeat (H) @(posedge sys_clk);
        r = sda;
        scl <= 1'b0;
    endtask
    task start();
        @(posedge sys_clk) drv_low <= 1'b0;
        repeat (H) @(posedge sys_clk);
        scl <= 1'b1;
        repeat (H) @(posedge sys_clk);
        drv_low <= 1'b1;
        repeat (H) @(posedge sys_clk);
        scl <= 1'b0;
    endtask
    task stop();
        @(posedge sys_clk) drv_low <= 1'b1;
        repeat (H) @(posedge sys_clk);
        scl <= 1'b1;
        repeat (H) @(posedge sys_clk);
        drv_low <= 1'b0;
        repeat (H) @(posedge sys_clk);
    endtask
    task wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = !r;
    endtask
    // Last byte of a read is left unacknowledged
    task rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(last, r);
    endtask
endmodule // dis_i2c_master
`default_nettype wire

// [tb/tb_top.sv]
// Testbench for the dual serial slave ports block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        sys_clk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, strap, sync_f, clk_f;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, rd;
    wire  logic [31:0] wb_dat_o;
    wire  logic        wb_ack_o, ch_scl, ch_sda, ch_oe, lo_scl, lo_sda, lo_oe, standby_o;
    wire  logic [1:0]  core_enable_o, term_enable_o;
    int          miscompares = 0;
    int          checks_done = 0;

    dis_top i_dis_top (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .channel_serial_clock(ch_scl),
        .channel_serial_data_i(ch_sda), .channel_serial_data_o(), .channel_serial_data_oe(ch_oe),
        .local_serial_clock(lo_scl), .local_serial_data_i(lo_sda), .local_serial_data_o(),
        .local_serial_data_oe(lo_oe), .addr_strap_pin(strap), .sync_detect_flag(sync_f),
        .clock_detect_flag(clk_f), .standby_o(standby_o), .core_enable_o(core_enable_o),
        .term_enable_o(term_enable_o)
    );
    dis_i2c_master m_ch (.sys_clk(sys_clk), .slave_oe(ch_oe), .scl(ch_scl), .sda(ch_sda));
    dis_i2c_master m_lo (.sys_clk(sys_clk), .slave_oe(lo_oe), .scl(lo_scl), .sda(lo_sda));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = !sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        int t;
        t = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge sys_clk);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 20);
        if (t >= 20) miscompares++;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic s(input logic lo);
        if (lo) m_lo.start(); else m_ch.start();
    endtask
    task automatic p(input logic lo);
        if (lo) m_lo.stop(); else m_ch.stop();
    endtask
    task automatic w8(input logic lo, input logic [7:0] d, input logic exp);
        logic a;
        if (lo) m_lo.wbyte(d, a); else m_ch.wbyte(d, a);
        check({31'h0, a}, {31'h0, exp});
    endtask
    task automatic r8(input logic lo, input logic last, input logic [7:0] exp);
        logic [7:0] d;
        if (lo) m_lo.rbyte(last, d); else m_ch.rbyte(last, d);
        check({24'h0, d}, {24'h0, exp});
    endtask
    task automatic wr_seq(input logic lo, input logic [7:0] a, ptr, d0, d1);
        s(lo);
        w8(lo, a, 1'b1);
        w8(lo, ptr, 1'b1);
        w8(lo, d0, 1'b1);
        w8(lo, d1, 1'b1);
        p(lo);
    endtask
    task automatic rd_seq(input logic lo, input logic [7:0] a, ptr, e0, e1);
        s(lo);
        w8(lo, a, 1'b1);
        w8(lo, ptr, 1'b1);
        s(lo);
        w8(lo, a | 8'h01, 1'b1);
        r8(lo, 1'b0, e0);
        r8(lo, 1'b1, e1);
        p(lo);
    endtask
    task automatic nack(input logic lo, input logic [7:0] a);
        s(lo);
        w8(lo, a, 1'b0);
        p(lo);
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        miscompares++;
        tally_and_finish();
    end
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, clk_f} = 4'h0;
        {sync_f, strap, sys_rst} = 3'h7;
        wb_adr_i = 8'h00;
        wb_dat_i = 32'h0;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wb(0, 8'h00, 0, rd); check(rd, 32'h1);
        wb(0, 8'h04, 0, rd); check(rd, 32'h5);
        wb(0, 8'h08, 0, rd); check(rd, 32'h40);
        wb(0, 8'h0C, 0, rd); check(rd, 32'h50);
        wb(0, 8'h10, 0, rd); check(rd, 32'h70);
        wb(0, 8'h20, 0, rd); check(rd, 32'h0);
        clk_f <= 1'b1;
        wb(1, 8'h00, 32'h0, rd);
        wb(0, 8'h04, 0, rd); check(rd, 32'h7);
        check({30'h0, core_enable_o}, 32'h0);
        wb(1, 8'h00, 32'h3, rd);
        wb(0, 8'h00, 0, rd); check(rd, 32'h3);
        check({30'h0, core_enable_o}, 32'h2);
        $display("test registers done");
        wr_seq(0, 8'h74, 8'h10, 8'hA1, 8'hA2);
        rd_seq(0, 8'h74, 8'h10, 8'hA1, 8'hA2);
        wr_seq(0, 8'h74, 8'h08, 8'h5A, 8'h6B);
        s(0);
        w8(0, 8'h75, 1'b1);
        r8(0, 1'b0, 8'h5A);
        r8(0, 1'b1, 8'h6B);
        p(0);
        s(0);
        w8(0, 8'h74, 1'b1);
        w8(0, 8'h10, 1'b1);
        wb(1, 8'h00, 32'h7, rd);
        s(0);
        w8(0, 8'h75, 1'b1);
        r8(0, 1'b1, 8'h5A);
        p(0);
        nack(0, 8'h76);
        $display("test channel done");
        wr_seq(1, 8'h62, 8'h00, 8'h11, 8'h12);
        wr_seq(1, 8'h6A, 8'h00, 8'h22, 8'h23);
        rd_seq(1, 8'h62, 8'h00, 8'h11, 8'h12);
        nack(1, 8'h63);
        nack(1, 8'h60);
        wb(1, 8'h08, 32'h41, rd);
        wr_seq(1, 8'h82, 8'h00, 8'h33, 8'h34);
        nack(1, 8'h80);
        $display("test local done");
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
